/* File: hdl/hdsf_pkg.sv */
package hdsf_pkg;
    // channel count
    localparam int CH_N = 2;

    // register indices; byte address is index shifted by two
    localparam logic [7:0] IDX_TX0 = 8'h26;
    localparam logic [7:0] IDX_RX0 = 8'h28;
    localparam logic [7:0] IDX_TX1 = 8'h46;
    localparam logic [7:0] IDX_RX1 = 8'h48;
    localparam logic [7:0] IDX_CFG0 = 8'h60;
    localparam logic [7:0] IDX_CFG1 = 8'h62;
    localparam int IDX_SHIFT = 2;
    localparam int SEL_N = 6;

    // transmit status bit positions
    localparam int TX_DMA_DONE = 0;
    localparam int TX_ADDR_FAULT = 1;
    localparam int TX_BUS_FAULT = 2;
    localparam int TX_GRANT = 3;
    localparam int TX_FRAME_DONE = 4;
    localparam int TX_UNDERRUN = 5;

    // receive status bit positions
    localparam int RX_BUF_A_DONE = 0;
    localparam int RX_BUF_B_DONE = 1;
    localparam int RX_BUF_A_OVF = 2;
    localparam int RX_BUF_B_OVF = 3;
    localparam int RX_ADDR_FAULT = 4;
    localparam int RX_BUS_FAULT = 5;
    localparam int RX_RESIDUE_LSB = 8;
    localparam int RESIDUE_W = 3;
    localparam int RX_FIFO_OVF = 11;
    localparam int RX_CARRIER_CHG = 12;
    localparam int RX_CRC_FAULT = 13;
    localparam int RX_LINE_IDLE = 14;
    localparam int RX_CARRIER_LVL = 15;

    // sticky flag positions, cleared by writing zero
    localparam logic [15:0] TX_FLAG_MASK = 16'h0037;
    localparam logic [15:0] RX_FLAG_MASK = 16'h783F;

    // channel configuration bit positions
    localparam int CFG_TRANSPARENT = 0;
    localparam int CFG_KEEP_CRC_BAD = 1;
    localparam int CFG_GRANT_HIGH = 2;
    localparam int CFG_TX_READY = 3;
    localparam int CFG_RXA_READY = 4;
    localparam int CFG_RXB_READY = 5;
    localparam int CFG_NO_BUS_ERROR_INPUT_MODE = 8;
    localparam int CFG_SERIAL_CTRL_PORT = 9;
    localparam int CFG_TIMESLOT = 10;
    localparam logic [15:0] CFG_MODE_MASK = 16'h0707;
    localparam logic [15:0] CFG_RESET = 16'h0000;
endpackage : hdsf_pkg

/* File: hdl/hdsf_status_flags.sv */
// Functional notes
// - last transmit byte sets DMA done flag
// - select or acknowledge in transmit DMA: address fault
// - bus error in transmit DMA: fault, drop ready
// - no bus fault flags in that bus mode
// - bit 3 mirrors grant pin, asserted reads one
// - frame done after good frame and fill entry
// - line abort makes transmitter resend the frame
// - underrun sets flag, aborts frame, drops ready
// - flags stay set until host writes zero
// - packet mode frame stored sets buffer done
// - buffer length exceeded: overrun flag, switch buffer
// - transparent full buffer: overrun, continue other buffer
// - receive address fault drops active buffer ready
// - receive bus error drops active buffer ready
// - residue bit count held in three bits
// - receive fifo overrun sets flag, drops ready
// - carrier pin change sets flag when available
// - CRC fault flag only when keeping bad frames
// - fifteen ones set line idle flag
// - idle still present after clear sets again
// - bit 15 shows inverted carrier pin at read while available, else zero
// - host sets transmit ready, DMA clears it
// - receive ready set-only, cleared by DMA, disable
`timescale 1ns/1ps
module hdsf_status_flags #(
    parameter int ADDR_W = 12
) (
    input wire logic i_clk_sys,
    input wire logic i_srst,
    input wire logic i_hsel,
    input wire logic [ADDR_W-1:0] i_haddr,
    input wire logic [1:0] i_htrans,
    input wire logic i_hwrite,
    input wire logic [2:0] i_hsize,
    input wire logic [31:0] i_hwdata,
    input wire logic i_hready,
    output logic o_hreadyout,
    output logic o_hresp,
    output logic [31:0] o_hrdata,
    input wire logic i_chip_select,
    input wire logic i_int_ack_input,
    input wire logic i_bus_error_input,
    input wire logic [1:0] i_tx_dma_cycle,
    input wire logic [1:0] i_tx_last_byte,
    input wire logic [1:0] i_tx_grant_pin,
    input wire logic [1:0] i_tx_frame_sent,
    input wire logic [1:0] i_tx_fill_entered,
    input wire logic [1:0] i_line_abort,
    input wire logic [1:0] i_tx_fifo_underrun,
    input wire logic [1:0] i_rx_dma_cycle,
    input wire logic [1:0] i_rx_frame_stored,
    input wire logic [1:0][2:0] i_rx_residue,
    input wire logic [1:0] i_rx_crc_bad,
    input wire logic [1:0] i_rx_buf_full,
    input wire logic [1:0] i_rx_fifo_overflow,
    input wire logic [1:0] i_rx_line_ones,
    input wire logic [1:0] i_carrier_level_n,
    input wire logic [1:0] i_rx_disable,
    output logic [1:0] o_tx_buffer_ready,
    output logic [1:0] o_rx_buf_a_ready,
    output logic [1:0] o_rx_buf_b_ready,
    output logic [1:0] o_rx_use_buf_b,
    output logic [1:0] o_tx_abort,
    output logic [1:0] o_tx_resend,
    output logic [1:0] o_irq_cause
);
    localparam int CH_N = hdsf_pkg::CH_N;

    typedef struct packed {
        logic [CH_N-1:0][15:0] tx_flg;
        logic [CH_N-1:0][15:0] rx_flg;
        logic [CH_N-1:0][15:0] cfg;
        logic [CH_N-1:0] tx_rdy;
        logic [CH_N-1:0] rxa_rdy;
        logic [CH_N-1:0] rxb_rdy;
        logic [CH_N-1:0] use_b;
        logic [CH_N-1:0] sent_pend;
        logic [CH_N-1:0] grant;
        logic [CH_N-1:0] cd_prev;
        logic [CH_N-1:0] abort;
        logic [CH_N-1:0] resend;
        logic [hdsf_pkg::SEL_N-1:0] wr_sel;
        logic [31:0] rdata;
    } hdsf_state_t;

    hdsf_state_t state_reg;
    hdsf_state_t state_next;

    logic access;
    logic [hdsf_pkg::SEL_N-1:0] sel;
    logic [CH_N-1:0][15:0] tx_word;
    logic [CH_N-1:0][15:0] rx_word;
    logic [CH_N-1:0][15:0] cfg_word;
    logic [15:0] rd16;

    // address match for one register index
    function automatic logic idx_hit(input logic [ADDR_W-1:0] addr, input logic [7:0] idx);
        logic [31:0] byte_addr;
        byte_addr = 32'(idx) << hdsf_pkg::IDX_SHIFT;
        return addr == byte_addr[ADDR_W-1:0];
    endfunction : idx_hit

    // address phase decode; zero wait states, always okay
    assign access = i_hsel & i_htrans[1] & i_hready;
    assign sel[0] = idx_hit(i_haddr, hdsf_pkg::IDX_TX0);
    assign sel[1] = idx_hit(i_haddr, hdsf_pkg::IDX_RX0);
    assign sel[2] = idx_hit(i_haddr, hdsf_pkg::IDX_TX1);
    assign sel[3] = idx_hit(i_haddr, hdsf_pkg::IDX_RX1);
    assign sel[4] = idx_hit(i_haddr, hdsf_pkg::IDX_CFG0);
    assign sel[5] = idx_hit(i_haddr, hdsf_pkg::IDX_CFG1);

    // read views of the registers, unused bits zero
    always_comb
    begin
        for (int c = 0; c < CH_N; c++)
        begin
            tx_word[c] = state_reg.tx_flg[c] & hdsf_pkg::TX_FLAG_MASK;
            tx_word[c][hdsf_pkg::TX_GRANT] = state_reg.grant[c];
            rx_word[c] = state_reg.rx_flg[c];
            rx_word[c][hdsf_pkg::RX_CARRIER_LVL] = ~i_carrier_level_n[c];
            if (state_reg.cfg[c][hdsf_pkg::CFG_SERIAL_CTRL_PORT] | state_reg.cfg[c][hdsf_pkg::CFG_TIMESLOT])
            begin
                rx_word[c][hdsf_pkg::RX_CARRIER_LVL] = 1'b0; // pin not available
            end
            cfg_word[c] = state_reg.cfg[c] & hdsf_pkg::CFG_MODE_MASK;
            cfg_word[c][hdsf_pkg::CFG_TX_READY] = state_reg.tx_rdy[c];
            cfg_word[c][hdsf_pkg::CFG_RXA_READY] = state_reg.rxa_rdy[c];
            cfg_word[c][hdsf_pkg::CFG_RXB_READY] = state_reg.rxb_rdy[c];
        end
    end

    // read mux; unmapped addresses read zero
    always_comb
    begin
        rd16 = hdsf_pkg::CFG_RESET;
        case (1'b1)
            sel[0]: rd16 = tx_word[0];
            sel[1]: rd16 = rx_word[0];
            sel[2]: rd16 = tx_word[1];
            sel[3]: rd16 = rx_word[1];
            sel[4]: rd16 = cfg_word[0];
            sel[5]: rd16 = cfg_word[1];
            default: rd16 = hdsf_pkg::CFG_RESET;
        endcase
    end

    // next state: bus slave and per-channel flag logic
    always_comb
    begin
        logic [15:0] tx_set;
        logic [15:0] tx_clr;
        logic [15:0] rx_set;
        logic [15:0] rx_clr;
        logic tx_rdy_drop;
        logic act_drop;
        logic addr_fault;
        logic bus_error_input_ok;
        logic packet;
        logic act_b;
        logic cfg_wr;
        tx_set = '0;
        tx_clr = '0;
        rx_set = '0;
        rx_clr = '0;
        tx_rdy_drop = 1'b0;
        act_drop = 1'b0;
        addr_fault = 1'b0;
        bus_error_input_ok = 1'b0;
        packet = 1'b0;
        act_b = 1'b0;
        cfg_wr = 1'b0;
        state_next = state_reg;
        state_next.wr_sel = '0;
        if (access)
        begin
            if (i_hwrite)
            begin
                state_next.wr_sel = sel;
            end
            else
            begin
                state_next.rdata = {16'h0000, rd16};
            end
        end
        addr_fault = i_chip_select | i_int_ack_input;
        for (int c = 0; c < CH_N; c++)
        begin
            tx_set = '0;
            rx_set = '0;
            tx_clr = '0;
            rx_clr = '0;
            tx_rdy_drop = 1'b0;
            act_drop = 1'b0;
            cfg_wr = state_reg.wr_sel[4 + c];
            bus_error_input_ok = ~state_reg.cfg[c][hdsf_pkg::CFG_NO_BUS_ERROR_INPUT_MODE];
            packet = ~state_reg.cfg[c][hdsf_pkg::CFG_TRANSPARENT];
            act_b = state_reg.use_b[c];
            // host clears by writing zero; a one leaves the flag alone
            if (state_reg.wr_sel[2 * c])
            begin
                tx_clr = ~i_hwdata[15:0] & hdsf_pkg::TX_FLAG_MASK;
            end
            if (state_reg.wr_sel[2 * c + 1])
            begin
                rx_clr = ~i_hwdata[15:0] & hdsf_pkg::RX_FLAG_MASK;
            end
            // transmit events
            if (i_tx_last_byte[c])
            begin
                tx_set[hdsf_pkg::TX_DMA_DONE] = 1'b1;
                tx_rdy_drop = 1'b1;
            end
            if (i_tx_dma_cycle[c] & addr_fault)
            begin
                tx_set[hdsf_pkg::TX_ADDR_FAULT] = 1'b1;
                tx_rdy_drop = 1'b1;
            end
            if (i_tx_dma_cycle[c] & i_bus_error_input & bus_error_input_ok)
            begin
                tx_set[hdsf_pkg::TX_BUS_FAULT] = 1'b1;
                tx_rdy_drop = 1'b1;
            end
            if (i_tx_fifo_underrun[c])
            begin
                tx_set[hdsf_pkg::TX_UNDERRUN] = 1'b1;
                tx_rdy_drop = 1'b1;
            end
            state_next.abort[c] = i_tx_fifo_underrun[c];
            state_next.resend[c] = i_line_abort[c];
            // frame done waits for fill state after a good frame
            if (i_tx_frame_sent[c])
            begin
                state_next.sent_pend[c] = 1'b1;
            end
            if (i_line_abort[c] | i_tx_fifo_underrun[c])
            begin
                state_next.sent_pend[c] = 1'b0;
            end
            else if (i_tx_fill_entered[c] & (state_reg.sent_pend[c] | i_tx_frame_sent[c]))
            begin
                tx_set[hdsf_pkg::TX_FRAME_DONE] = 1'b1;
                state_next.sent_pend[c] = 1'b0;
            end
            // grant pin mirror, polarity by mode
            if (state_reg.cfg[c][hdsf_pkg::CFG_GRANT_HIGH])
            begin
                state_next.grant[c] = i_tx_grant_pin[c];
            end
            else
            begin
                state_next.grant[c] = ~i_tx_grant_pin[c];
            end
            // receive events on the active buffer
            if (i_rx_frame_stored[c] & packet)
            begin
                rx_set[act_b ? hdsf_pkg::RX_BUF_B_DONE : hdsf_pkg::RX_BUF_A_DONE] = 1'b1;
                act_drop = 1'b1;
                if (i_rx_crc_bad[c] & state_reg.cfg[c][hdsf_pkg::CFG_KEEP_CRC_BAD])
                begin
                    rx_set[hdsf_pkg::RX_CRC_FAULT] = 1'b1;
                end
            end
            if (i_rx_buf_full[c])
            begin
                rx_set[act_b ? hdsf_pkg::RX_BUF_B_OVF : hdsf_pkg::RX_BUF_A_OVF] = 1'b1;
                act_drop = 1'b1;
            end
            if (i_rx_dma_cycle[c] & addr_fault)
            begin
                rx_set[hdsf_pkg::RX_ADDR_FAULT] = 1'b1;
                act_drop = 1'b1;
            end
            if (i_rx_dma_cycle[c] & i_bus_error_input & bus_error_input_ok)
            begin
                rx_set[hdsf_pkg::RX_BUS_FAULT] = 1'b1;
                act_drop = 1'b1;
            end
            if (i_rx_fifo_overflow[c])
            begin
                rx_set[hdsf_pkg::RX_FIFO_OVF] = 1'b1;
                act_drop = 1'b1;
            end
            // carrier change, only while the pin is available; active level kept so reset matches an idle pin
            state_next.cd_prev[c] = ~i_carrier_level_n[c];
            if (~state_reg.cfg[c][hdsf_pkg::CFG_SERIAL_CTRL_PORT] & ~state_reg.cfg[c][hdsf_pkg::CFG_TIMESLOT]
                & (~i_carrier_level_n[c] != state_reg.cd_prev[c]))
            begin
                rx_set[hdsf_pkg::RX_CARRIER_CHG] = 1'b1;
            end
            // idle level keeps setting, so a clear during idle sets again
            if (i_rx_line_ones[c])
            begin
                rx_set[hdsf_pkg::RX_LINE_IDLE] = 1'b1;
            end
            // sticky update, set wins over clear
            state_next.tx_flg[c] = ((state_reg.tx_flg[c] & ~tx_clr) | tx_set) & hdsf_pkg::TX_FLAG_MASK;
            state_next.rx_flg[c] = ((state_reg.rx_flg[c] & ~rx_clr) | rx_set) & hdsf_pkg::RX_FLAG_MASK;
            if (i_rx_frame_stored[c] & packet)
            begin
                state_next.rx_flg[c][hdsf_pkg::RX_RESIDUE_LSB +: hdsf_pkg::RESIDUE_W] = i_rx_residue[c];
            end
            else
            begin
                state_next.rx_flg[c][hdsf_pkg::RX_RESIDUE_LSB +: hdsf_pkg::RESIDUE_W] =
                    state_reg.rx_flg[c][hdsf_pkg::RX_RESIDUE_LSB +: hdsf_pkg::RESIDUE_W];
            end
            // transmit ready: host write wins over a DMA clear
            if (tx_rdy_drop)
            begin
                state_next.tx_rdy[c] = 1'b0;
            end
            if (cfg_wr)
            begin
                state_next.tx_rdy[c] = i_hwdata[hdsf_pkg::CFG_TX_READY];
                state_next.cfg[c] = i_hwdata[15:0] & hdsf_pkg::CFG_MODE_MASK;
            end
            // receive ready: cleared on the active buffer or disable, host sets only
            if (act_drop & ~act_b)
            begin
                state_next.rxa_rdy[c] = 1'b0;
            end
            if (act_drop & act_b)
            begin
                state_next.rxb_rdy[c] = 1'b0;
            end
            if (i_rx_disable[c])
            begin
                state_next.rxa_rdy[c] = 1'b0;
                state_next.rxb_rdy[c] = 1'b0;
            end
            if (cfg_wr & i_hwdata[hdsf_pkg::CFG_RXA_READY])
            begin
                state_next.rxa_rdy[c] = 1'b1;
            end
            if (cfg_wr & i_hwdata[hdsf_pkg::CFG_RXB_READY])
            begin
                state_next.rxb_rdy[c] = 1'b1;
            end
            // move to the other buffer once the active one is not ready
            if (act_b ? ~state_next.rxb_rdy[c] : ~state_next.rxa_rdy[c])
            begin
                if (state_next.rxa_rdy[c])
                begin
                    state_next.use_b[c] = 1'b0;
                end
                else if (state_next.rxb_rdy[c])
                begin
                    state_next.use_b[c] = 1'b1;
                end
            end
        end
    end

    // state register
    always_ff @(posedge i_clk_sys)
    begin
        if (i_srst)
        begin
            state_reg <= '0;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    // outputs
    assign o_hreadyout = 1'b1;
    assign o_hresp = 1'b0;
    assign o_hrdata = state_reg.rdata;
    assign o_tx_buffer_ready = state_reg.tx_rdy;
    assign o_rx_buf_a_ready = state_reg.rxa_rdy;
    assign o_rx_buf_b_ready = state_reg.rxb_rdy;
    assign o_rx_use_buf_b = state_reg.use_b;
    assign o_tx_abort = state_reg.abort;
    assign o_tx_resend = state_reg.resend;

    // pending cause per channel from any sticky flag
    always_comb
    begin
        for (int c = 0; c < CH_N; c++)
        begin
            o_irq_cause[c] = (|(state_reg.tx_flg[c] & hdsf_pkg::TX_FLAG_MASK))
                | (|(state_reg.rx_flg[c] & hdsf_pkg::RX_FLAG_MASK));
        end
    end
endmodule : hdsf_status_flags

/* File: tb/hdsf_host_bfm.sv */
`timescale 1ns/1ps
module hdsf_host_bfm (
    input wire logic i_clk_sys,
    input wire logic i_hready,
    input wire logic [31:0] i_hrdata,
    output logic o_hsel,
    output logic [11:0] o_haddr,
    output logic [1:0] o_htrans,
    output logic o_hwrite,
    output logic [2:0] o_hsize,
    output logic [31:0] o_hwdata
);
    // bus idle from time zero
    initial
    begin
        o_hsel = 1'b0;
        o_haddr = 12'h000;
        o_htrans = 2'h0;
        o_hwrite = 1'b0;
        o_hsize = 3'h2;
        o_hwdata = 32'h0;
    end

    // one single word transfer, address phase then data phase
    task xfer(input logic wr, input logic [11:0] a, input logic [31:0] wd, output logic [31:0] rd);
        @(posedge i_clk_sys);
        o_hsel <= 1'b1;
        o_haddr <= a;
        o_htrans <= 2'h2;
        o_hwrite <= wr;
        o_hsize <= 3'h2;
        do @(posedge i_clk_sys); while (i_hready !== 1'b1);
        o_htrans <= 2'h0;
        o_hwdata <= wd;
        do @(posedge i_clk_sys); while (i_hready !== 1'b1);
        rd = i_hrdata;
        o_hsel <= 1'b0;
    endtask : xfer
endmodule : hdsf_host_bfm

/* File: tb/hdsf_status_flags_asserts.sv */
`timescale 1ns/1ps
module hdsf_status_flags_asserts (
    input wire logic i_clk_sys,
    input wire logic i_srst,
    input wire logic i_chip_select,
    input wire logic i_int_ack_input,
    input wire logic [1:0] i_tx_dma_cycle,
    input wire logic [1:0] i_tx_last_byte,
    input wire logic [1:0] i_line_abort,
    input wire logic [1:0] i_tx_fifo_underrun,
    input wire logic [1:0] i_rx_buf_full,
    input wire logic [1:0] i_rx_fifo_overflow,
    input wire logic [1:0] i_rx_line_ones,
    input wire logic o_hreadyout,
    input wire logic o_hresp,
    input wire logic [31:0] o_hrdata,
    input wire logic [1:0] o_tx_buffer_ready,
    input wire logic [1:0] o_rx_buf_a_ready,
    input wire logic [1:0] o_rx_use_buf_b,
    input wire logic [1:0] o_rx_buf_b_ready,
    input wire logic [1:0] o_tx_abort,
    input wire logic [1:0] o_tx_resend,
    input wire logic [1:0] o_irq_cause
);
    // all checks on the system clock, idle during reset
    default clocking cb @(posedge i_clk_sys);
    endclocking
    default disable iff (i_srst);

    // event inputs against flags, ready bits and pulses; read data and bus answer
    a_underrun_abort: assert property (i_tx_fifo_underrun[0] |=> o_tx_abort[0] && !o_tx_buffer_ready[0])
        else $error("underrun did not abort and drop ready");
    a_abort_has_cause: assert property (o_tx_abort[0] |-> $past(i_tx_fifo_underrun[0]))
        else $error("abort without underrun");
    a_resend_pulse: assert property (i_line_abort[0] |=> o_tx_resend[0] ##1 !o_tx_resend[0])
        else $error("line abort did not resend");
    a_dma_done_irq: assert property (i_tx_last_byte[0] |=> o_irq_cause[0])
        else $error("dma done raised no interrupt");
    a_addr_fault_irq: assert property ((i_chip_select || i_int_ack_input) && i_tx_dma_cycle[0] |=> o_irq_cause[0])
        else $error("address fault raised no interrupt");
    a_fifo_ovf_irq: assert property (i_rx_fifo_overflow[1] |=> o_irq_cause[1])
        else $error("fifo overrun raised no interrupt");
    a_idle_hold: assert property (i_rx_line_ones[0] [*2] |-> o_irq_cause[0])
        else $error("idle line did not keep interrupt");
    a_buf_switch: assert property (i_rx_buf_full[0] && !o_rx_use_buf_b[0] && o_rx_buf_b_ready[0]
        |=> !o_rx_buf_a_ready[0] ##[0:2] o_rx_use_buf_b[0])
        else $error("full buffer a did not switch to b");
    a_upper_zero: assert property (o_hrdata[31:16] == 16'h0000)
        else $error("upper read data not zero");
    a_bus_okay: assert property (o_hreadyout && !o_hresp)
        else $error("bus answer not ready okay");

    // main scenarios reached
    c_underrun: cover property (i_tx_fifo_underrun[0]);
    c_buf_switch: cover property (i_rx_buf_full[0] && o_rx_buf_b_ready[0]);
    c_resend: cover property (o_tx_resend[0]);
endmodule : hdsf_status_flags_asserts

/* File: tb/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
    localparam logic [11:0] A_TX0 = {2'h0, hdsf_pkg::IDX_TX0, 2'h0};
    localparam logic [11:0] A_RX0 = {2'h0, hdsf_pkg::IDX_RX0, 2'h0};
    localparam logic [11:0] A_TX1 = {2'h0, hdsf_pkg::IDX_TX1, 2'h0};
    localparam logic [11:0] A_RX1 = {2'h0, hdsf_pkg::IDX_RX1, 2'h0};
    localparam logic [11:0] A_CF0 = {2'h0, hdsf_pkg::IDX_CFG0, 2'h0};
    localparam logic [11:0] A_CF1 = {2'h0, hdsf_pkg::IDX_CFG1, 2'h0};
    localparam int E_LAST = 0, E_SENT = 2, E_FILL = 4, E_ABT = 6, E_UND = 8, E_STOR = 10;
    localparam int E_FULL = 12, E_FOVF = 14, E_DIS = 16, E_CS = 18, E_INT_ACK_INPUT = 19, E_BUS_ERROR_INPUT = 20;
    logic clk, srst, hsel, hwrite, hready, hresp;
    logic [11:0] haddr;
    logic [1:0] htrans, dma_tx, dma_rx, grant, crc, ones, cd_n;
    logic [2:0] hsize;
    logic [31:0] hwdata, hrdata;
    logic [20:0] ev;
    logic [1:0][2:0] res;
    logic [1:0] tx_rdy, ra_rdy, rb_rdy, use_b, abrt, resend, irq;
    int error_cnt = 0, checks = 0, cyc = 0;

    hdsf_status_flags #(.ADDR_W(12)) dut (
        .i_clk_sys(clk), .i_srst(srst), .i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans),
        .i_hwrite(hwrite), .i_hsize(hsize), .i_hwdata(hwdata), .i_hready(hready),
        .o_hreadyout(hready), .o_hresp(hresp), .o_hrdata(hrdata),
        .i_chip_select(ev[E_CS]), .i_int_ack_input(ev[E_INT_ACK_INPUT]), .i_bus_error_input(ev[E_BUS_ERROR_INPUT]),
        .i_tx_dma_cycle(dma_tx), .i_tx_last_byte(ev[1:0]), .i_tx_grant_pin(grant),
        .i_tx_frame_sent(ev[3:2]), .i_tx_fill_entered(ev[5:4]), .i_line_abort(ev[7:6]),
        .i_tx_fifo_underrun(ev[9:8]), .i_rx_dma_cycle(dma_rx), .i_rx_frame_stored(ev[11:10]),
        .i_rx_residue(res), .i_rx_crc_bad(crc), .i_rx_buf_full(ev[13:12]),
        .i_rx_fifo_overflow(ev[15:14]), .i_rx_line_ones(ones), .i_carrier_level_n(cd_n),
        .i_rx_disable(ev[17:16]), .o_tx_buffer_ready(tx_rdy), .o_rx_buf_a_ready(ra_rdy),
        .o_rx_buf_b_ready(rb_rdy), .o_rx_use_buf_b(use_b), .o_tx_abort(abrt),
        .o_tx_resend(resend), .o_irq_cause(irq)
    );

    hdsf_host_bfm host (
        .i_clk_sys(clk), .i_hready(hready), .i_hrdata(hrdata), .o_hsel(hsel), .o_haddr(haddr),
        .o_htrans(htrans), .o_hwrite(hwrite), .o_hsize(hsize), .o_hwdata(hwdata)
    );

    // 40 MHz system clock
    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    task chk(input logic [31:0] g, input logic [31:0] e);
        checks++;
        if (g !== e)
        begin
            error_cnt++;
            $display("wrong value at %0t: got %h exp %h", $time, g, e);
        end
    endtask : chk

    task wr(input logic [11:0] a, input logic [15:0] d);
        logic [31:0] r;
        host.xfer(1'b1, a, {16'h0000, d}, r);
        @(negedge clk);
    endtask : wr

    task rc(input logic [11:0] a, input logic [15:0] e);
        logic [31:0] r;
        host.xfer(1'b0, a, 32'h0, r);
        chk(r, {16'h0000, e});
    endtask : rc

    // one cycle event pulse, settled on return
    task pulse(input logic [20:0] m);
        @(posedge clk);
        ev <= m;
        @(posedge clk);
        ev <= 21'h0;
        @(negedge clk);
    endtask : pulse

    task done(input string s);
        $display("test %s finished", s);
    endtask : done

    task tally_and_finish;
        $display("checks %0d mismatches %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : tally_and_finish

    // hang guard
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 3000)
        begin
            error_cnt++;
            tally_and_finish();
        end
    end

    // main sequence
    initial
    begin
        srst = 1'b1;
        ev = 21'h0;
        dma_tx = 2'h0;
        dma_rx = 2'h0;
        grant = 2'h3;
        crc = 2'h0;
        ones = 2'h0;
        cd_n = 2'h3;
        res = 6'h00;
        repeat (6) @(posedge clk);
        srst <= 1'b0;
        rc(A_TX0, 16'h0000);
        rc(A_RX1, 16'h0000);
        wr(12'h004, 16'hFFFF);
        rc(12'h004, 16'h0000);
        done("reset");
        wr(A_CF0, 16'h0008);
        chk({31'h0, tx_rdy[0]}, 32'h1);
        pulse(21'h1 << E_LAST);
        rc(A_TX0, 16'h0001);
        chk({31'h0, tx_rdy[0]}, 32'h0);
        wr(A_TX0, 16'hFFFF);
        rc(A_TX0, 16'h0001);
        wr(A_TX0, 16'h0000);
        rc(A_TX0, 16'h0000);
        @(posedge clk);
        grant <= 2'h2;
        repeat (3) @(posedge clk);
        rc(A_TX0, 16'h0008);
        wr(A_CF0, 16'h0004);
        rc(A_TX0, 16'h0000);
        @(posedge clk);
        grant <= 2'h3;
        repeat (3) @(posedge clk);
        rc(A_TX0, 16'h0008);
        done("tx done and grant");
        wr(A_CF0, 16'h0008);
        pulse(21'h1 << E_UND);
        chk({30'h0, tx_rdy}, 32'h0);
        pulse((21'h1 << E_SENT) | (21'h1 << E_FILL));
        rc(A_TX0, 16'h0030);
        wr(A_TX0, 16'h0000);
        pulse(21'h1 << E_SENT);
        pulse((21'h1 << E_ABT) | (21'h1 << E_FILL));
        rc(A_TX0, 16'h0000);
        done("underrun and frame");
        @(posedge clk);
        dma_tx <= 2'h1;
        for (int i = 0; i < 3; i++)
        begin
            wr(A_CF0, 16'h0008);
            pulse(21'h1 << (E_CS + i));
            rc(A_TX0, (i == 2) ? 16'h0004 : 16'h0002);
            chk({31'h0, tx_rdy[0]}, 32'h0);
            wr(A_TX0, 16'h0000);
        end
        wr(A_CF0, 16'h0100);
        pulse(21'h1 << E_BUS_ERROR_INPUT);
        rc(A_TX0, 16'h0000);
        rc(A_TX1, 16'h0000);
        @(posedge clk);
        dma_tx <= 2'h0;
        done("tx faults");
        wr(A_CF0, 16'h0000);
        @(posedge clk);
        crc <= 2'h2;
        res <= 6'h28;
        wr(A_CF1, 16'h0012);
        pulse(21'h1 << (E_STOR + 1));
        rc(A_RX1, 16'h2501);
        chk({31'h0, ra_rdy[1]}, 32'h0);
        wr(A_RX1, 16'h0000);
        wr(A_CF1, 16'h0020);
        pulse(21'h1 << (E_STOR + 1));
        rc(A_RX1, 16'h0502);
        wr(A_RX1, 16'h0000);
        wr(A_CF1, 16'h0011);
        pulse(21'h1 << (E_STOR + 1));
        rc(A_RX1, 16'h0500);
        pulse(21'h1 << (E_FOVF + 1));
        rc(A_RX1, 16'h0D00);
        chk({31'h0, ra_rdy[1]}, 32'h0);
        done("rx frames");
        wr(A_CF0, 16'h0030);
        pulse(21'h1 << E_FULL);
        chk({30'h0, ra_rdy[0], use_b[0]}, 32'h1);
        pulse(21'h1 << E_FULL);
        chk({31'h0, rb_rdy[0]}, 32'h0);
        @(posedge clk);
        dma_rx <= 2'h1;
        wr(A_CF0, 16'h0010);
        pulse(21'h1 << E_INT_ACK_INPUT);
        chk({31'h0, ra_rdy[0]}, 32'h0);
        wr(A_CF0, 16'h0020);
        pulse(21'h1 << E_BUS_ERROR_INPUT);
        chk({31'h0, rb_rdy[0]}, 32'h0);
        rc(A_RX0, 16'h003C);
        @(posedge clk);
        dma_rx <= 2'h0;
        wr(A_CF0, 16'h0010);
        pulse(21'h1 << E_DIS);
        chk({31'h0, ra_rdy[0]}, 32'h0);
        done("rx buffers");
        wr(A_RX0, 16'h0000);
        @(posedge clk);
        ones <= 2'h1;
        repeat (2) @(posedge clk);
        wr(A_RX0, 16'h0000);
        rc(A_RX0, 16'h4000);
        @(posedge clk);
        ones <= 2'h0;
        wr(A_RX0, 16'h0000);
        @(posedge clk);
        cd_n <= 2'h2;
        repeat (3) @(posedge clk);
        rc(A_RX0, 16'h9000);
        wr(A_RX0, 16'h0000);
        wr(A_RX1, 16'h0000);
        chk({30'h0, irq}, 32'h0);
        rc(A_RX0, 16'h8000);
        wr(A_CF0, 16'h0200);
        @(posedge clk);
        cd_n <= 2'h3;
        rc(A_RX0, 16'h0000);
        done("idle and carrier");
        tally_and_finish();
    end
endmodule : tb_top

bind hdsf_status_flags hdsf_status_flags_asserts u_chk (
    .i_clk_sys(i_clk_sys), .i_srst(i_srst), .i_chip_select(i_chip_select),
    .i_int_ack_input(i_int_ack_input), .i_tx_dma_cycle(i_tx_dma_cycle), .i_tx_last_byte(i_tx_last_byte),
    .i_line_abort(i_line_abort), .i_tx_fifo_underrun(i_tx_fifo_underrun), .i_rx_buf_full(i_rx_buf_full),
    .i_rx_fifo_overflow(i_rx_fifo_overflow), .i_rx_line_ones(i_rx_line_ones), .o_hreadyout(o_hreadyout),
    .o_hresp(o_hresp), .o_hrdata(o_hrdata), .o_tx_buffer_ready(o_tx_buffer_ready),
    .o_rx_buf_a_ready(o_rx_buf_a_ready), .o_rx_use_buf_b(o_rx_use_buf_b), .o_rx_buf_b_ready(o_rx_buf_b_ready),
    .o_tx_abort(o_tx_abort), .o_tx_resend(o_tx_resend), .o_irq_cause(o_irq_cause)
);
